// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import timer_unit_pkg::*;
    logic mclk, sys_rst, avs_read, avs_write, tx_end, rx_first_bits;
    logic lfo_in, timer2_underflow;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest, timer0_active_flag, timer1_active_flag;
    logic timer0_underflow_irq_flag, timer_one_underflow_irq_flag;
    int errors, checks_done, seed;
    logic [7:0] rd, run_m, v;

    reader_frontend_timer_unit reader_frontend_timer_unit_i (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_end(tx_end), .rx_first_bits(rx_first_bits), .lfo_in(lfo_in),
        .timer2_underflow(timer2_underflow),
        .timer0_active_flag(timer0_active_flag),
        .timer1_active_flag(timer1_active_flag),
        .timer0_underflow_irq_flag(timer0_underflow_irq_flag),
        .timer_one_underflow_irq_flag(timer_one_underflow_irq_flag)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Reserved bits 6 and 2 drop out
    function automatic logic [7:0] ctrl_read(input logic [7:0] w);
        return {w[7], 1'b0, w[5:3], 1'b0, w[1:0]};
    endfunction

    // Only masked running bits follow the write
    function automatic logic [7:0] run_next(input logic [7:0] old,
                                            input logic [7:0] w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 4; i++) begin
            r[i+4] = w[i] ? w[i+4] : old[i+4];
        end
        return r;
    endfunction

    function automatic logic sig(input int sel);
        case (sel)
            0: return timer0_active_flag;
            1: return timer1_active_flag;
            2: return timer0_underflow_irq_flag;
            default: return timer_one_underflow_irq_flag;
        endcase
    endfunction

    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves one edge after release
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d, input logic [3:0] be,
                       output logic [7:0] q);
        logic w;
        int n;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        n = 0;
        w = 1'b1;
        while (w) begin
            @(posedge mclk);
            w = avs_waitrequest;
            q = avs_readdata[7:0];
            n++;
            if (n > 20) begin
                errors++;
                $display("[ERR] waitrequest expected 0 seen 1");
                finish_test();
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rdc(input string name, input logic [4:0] a,
                       input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 4'h1, q);
        check(name, exp, q);
    endtask

    task automatic pulse(input int sel);
        case (sel)
            0: tx_end <= 1'b1;
            1: rx_first_bits <= 1'b1;
            default: timer2_underflow <= 1'b1;
        endcase
        @(posedge mclk);
        tx_end <= 1'b0;
        rx_first_bits <= 1'b0;
        timer2_underflow <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wait_sig(input string name, input int sel,
                            input logic val, input int max);
        int n;
        n = 0;
        while (sig(sel) !== val) begin
            @(posedge mclk);
            n++;
            if (n > max) begin
                errors++;
                $display("[ERR] %s expected %b seen %b", name, val, sig(sel));
                finish_test();
            end
        end
        checks_done++;
    endtask

    task automatic chk(input string name, input int sel, input logic val);
        check(name, {7'h00, val}, {7'h00, sig(sel)});
    endtask

    initial begin
        seed = 32'h0000_6439;
        sys_rst = 1'b1;
        {avs_read, avs_write, tx_end, rx_first_bits} = 4'h0;
        lfo_in = 1'b0;
        timer2_underflow = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        errors = 0;
        checks_done = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int a = 14; a <= 26; a++) rdc("reset value", a[4:0], 8'h00);
        wr(IDX_T0_CNTH, 8'h55);
        wr(IDX_T0_CNTL, 8'haa);
        rdc("count high", IDX_T0_CNTH, 8'h00);
        rdc("count low", IDX_T0_CNTL, 8'h00);
        wr(5'h1f, 8'hff);
        rdc("unmapped", 5'h1f, 8'h00);
        $display("test reset done");
        repeat (8) begin
            v = 8'($random(seed));
            wr(IDX_T0_CTRL, v);
            rdc("t0 control", IDX_T0_CTRL, ctrl_read(v));
            v = 8'($random(seed));
            wr(IDX_T1_CTRL, v);
            rdc("t1 control", IDX_T1_CTRL, ctrl_read(v));
            v = 8'($random(seed));
            wr(IDX_T0_RLL, v);
            rdc("reload low", IDX_T0_RLL, v);
        end
        wr(IDX_T0_CTRL, 8'h01);
        bus(1'b1, IDX_T0_CTRL, 8'hff, 4'h0, rd);
        rdc("no byte enable", IDX_T0_CTRL, 8'h01);
        $display("test registers done");
        // Slow clock, full reload: no underflow during this test
        wr(IDX_T1_CTRL, 8'h01);
        for (int a = 16; a <= 17; a++) wr(a[4:0], 8'hff);
        for (int a = 21; a <= 22; a++) wr(a[4:0], 8'hff);
        run_m = 8'h00;
        for (int i = 0; i < 14; i++) begin
            v = (i == 12) ? 8'hf0 : (i == 13) ? 8'h0f : 8'($random(seed));
            wr(IDX_RUN, v);
            run_m = run_next(run_m, v);
            rdc("run control", IDX_RUN, run_m);
            chk("t0 active", 0, run_m[4]);
            chk("t1 active", 1, run_m[5]);
        end
        $display("test run control done");
        wr(IDX_T0_RLH, 8'h00);
        wr(IDX_T0_RLL, 8'h02);
        wr(IDX_T0_CTRL, 8'h00);
        wr(IDX_FLAGS, 8'h03);
        wr(IDX_RUN, 8'h11);
        repeat (30) @(posedge mclk);
        chk("one shot running", 0, 1'b1);
        wait_sig("one shot stop", 0, 1'b0, 60);
        rdc("count at stop", IDX_T0_CNTL, 8'h00);
        wait_sig("t0 flag", 2, 1'b1, 4);
        wr(IDX_FLAGS, 8'h01);
        chk("t0 flag clear", 2, 1'b0);
        wr(IDX_T0_RLL, 8'h03);
        wr(IDX_T0_CTRL, 8'h08);
        wr(IDX_RUN, 8'h11);
        for (int i = 0; i < 2; i++) begin
            wait_sig("restart flag", 2, 1'b1, 200);
            chk("still running", 0, 1'b1);
            wr(IDX_FLAGS, 8'h01);
        end
        wr(IDX_RUN, 8'h01);
        chk("masked stop", 0, 1'b0);
        $display("test underflow done");
        wr(IDX_T0_RLH, 8'h10);
        wr(IDX_T0_RLL, 8'h00);
        wr(IDX_T0_CTRL, 8'h01);
        pulse(0);
        repeat (3) @(posedge mclk);
        chk("mode 00 no start", 0, 1'b0);
        // Cascade clock idle, so no tick can blur the loaded value
        wr(IDX_T0_CTRL, 8'h12);
        pulse(0);
        wait_sig("tx end start", 0, 1'b1, 4);
        rdc("loaded high", IDX_T0_CNTH, 8'h10);
        wr(IDX_T0_RLH, 8'h55);
        rdc("count kept", IDX_T0_CNTH, 8'h10);
        rdc("reload high", IDX_T0_RLH, 8'h55);
        wr(IDX_T0_CTRL, 8'h11);
        repeat (2500) @(posedge mclk);
        rdc("live count", IDX_T0_CNTH, 8'h0f);
        pulse(1);
        repeat (3) @(posedge mclk);
        chk("no auto stop", 0, 1'b1);
        wr(IDX_T0_CTRL, 8'h91);
        pulse(1);
        wait_sig("stop on receive", 0, 1'b0, 3);
        $display("test start modes done");
        wr(IDX_T0_CTRL, 8'ha1);
        wr(IDX_T1_CTRL, 8'ha1);
        lfo_in <= 1'b1;
        wait_sig("trim start", 0, 1'b1, 8);
        wait_sig("t1 trim start", 1, 1'b1, 8);
        pulse(1);
        repeat (3) @(posedge mclk);
        chk("trim ignores receive", 0, 1'b1);
        chk("t1 trim ignores receive", 1, 1'b1);
        lfo_in <= 1'b0;
        repeat (6) @(posedge mclk);
        lfo_in <= 1'b1;
        wait_sig("trim stop", 0, 1'b0, 8);
        wait_sig("t1 trim stop", 1, 1'b0, 8);
        lfo_in <= 1'b0;
        wr(IDX_T0_RLH, 8'h00);
        wr(IDX_T0_RLL, 8'h00);
        wr(IDX_T0_CTRL, 8'h32);
        wr(IDX_FLAGS, 8'h03);
        lfo_in <= 1'b1;
        wait_sig("trim uf start", 0, 1'b1, 8);
        pulse(2);
        wait_sig("trim uf stop", 0, 1'b0, 4);
        wait_sig("trim uf flag", 2, 1'b1, 4);
        lfo_in <= 1'b0;
        $display("test trimming done");
        wr(IDX_T0_CTRL, 8'h02);
        wr(IDX_T0_RLH, 8'h00);
        wr(IDX_T0_RLL, 8'h01);
        wr(IDX_FLAGS, 8'h03);
        wr(IDX_RUN, 8'h11);
        pulse(2);
        repeat (3) @(posedge mclk);
        rdc("cascade count", IDX_T0_CNTL, 8'h00);
        pulse(2);
        wait_sig("cascade stop", 0, 1'b0, 6);
        wait_sig("cascade flag", 2, 1'b1, 4);
        wr(IDX_FLAGS, 8'h03);
        wr(IDX_T1_CTRL, 8'h83);
        wr(IDX_T1_RLL, 8'h02);
        wr(IDX_T1_RLH, 8'h00);
        wr(IDX_RUN, 8'h22);
        pulse(1);
        wait_sig("t1 stop on receive", 1, 1'b0, 4);
        wr(IDX_T1_CTRL, 8'h03);
        wr(IDX_T1_RLL, 8'h01);
        wr(IDX_T0_CTRL, 8'h03);
        wr(IDX_T0_RLL, 8'h00);
        wr(IDX_RUN, 8'h33);
        pulse(2);
        pulse(2);
        wait_sig("t1 from timer2", 1, 1'b0, 6);
        wait_sig("t1 flag", 3, 1'b1, 4);
        wait_sig("t0 from timer1", 0, 1'b0, 8);
        wait_sig("t0 flag", 2, 1'b1, 4);
        $display("test cascade done");
        finish_test();
    end
endmodule

// ### hw/reader_frontend_timer_unit.sv
`timescale 1ns/1ns
module reader_frontend_timer_unit
    import timer_unit_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tx_end,
    input wire logic rx_first_bits,
    input wire logic lfo_in,
    input wire logic timer2_underflow,
    output logic timer0_active_flag,
    output logic timer1_active_flag,
    output logic timer0_underflow_irq_flag,
    output logic timer_one_underflow_irq_flag
);

    function automatic logic sel_tick(input logic [1:0] sel,
                                      input logic t_fast,
                                      input logic t_slow,
                                      input logic uf_a,
                                      input logic uf_b);
        unique case (clk_sel_t'(sel))
            CLK_CARRIER: sel_tick = t_fast;
            CLK_SLOW: sel_tick = t_slow;
            CLK_UF_A: sel_tick = uf_a;
            CLK_UF_B: sel_tick = uf_b;
        endcase
    endfunction

    logic ack_r;
    logic req;
    logic wr_commit;
    logic be_ok;
    logic [7:0] wd;
    logic [DATA_W-1:0] rdata_r;
    logic [7:0] ctrl_r [NUM_TIMERS];
    logic [7:0] rlh_r [NUM_TIMERS];
    logic [7:0] rll_r [NUM_TIMERS];
    logic [CNT_W-1:0] cnt_r [NUM_TIMERS];
    logic run_r [NUM_TIMERS];
    logic uf_r [NUM_TIMERS];
    logic flag_r [NUM_TIMERS];
    logic wr_run [NUM_TIMERS];
    logic hw_start [NUM_TIMERS];
    logic hw_stop [NUM_TIMERS];
    logic uf_now [NUM_TIMERS];
    logic tick [NUM_TIMERS];
    logic [1:0] t23_r;
    logic rate_tick [2];
    logic lfo_s1_r;
    logic lfo_s2_r;
    logic lfo_s3_r;
    logic lfo_rise;
    logic run_wr_hit;

    // Bus slave: one wait state, answer on the second edge
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_commit = avs_write & ack_r;
    assign be_ok = avs_byteenable[0];
    assign wd = avs_writedata[7:0];
    assign avs_readdata = rdata_r;
    assign run_wr_hit = wr_commit & be_ok & (avs_address == IDX_RUN);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Count bytes are sampled live; mid-reception reads may tear
    // live count readback
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (avs_read & ~ack_r) begin
            rdata_r <= '0;
            unique case (avs_address)
                IDX_RUN: rdata_r[7:0] <= {t23_r[1], t23_r[0], run_r[1],
                    run_r[0], 4'h0};
                IDX_T0_CTRL: rdata_r[7:0] <= ctrl_r[0];
                IDX_T0_RLH: rdata_r[7:0] <= rlh_r[0];
                IDX_T0_RLL: rdata_r[7:0] <= rll_r[0];
                IDX_T0_CNTH: rdata_r[7:0] <= cnt_r[0][15:8];
                IDX_T0_CNTL: rdata_r[7:0] <= cnt_r[0][7:0];
                IDX_T1_CTRL: rdata_r[7:0] <= ctrl_r[1];
                IDX_T1_RLH: rdata_r[7:0] <= rlh_r[1];
                IDX_T1_RLL: rdata_r[7:0] <= rll_r[1];
                IDX_T1_CNTH: rdata_r[7:0] <= cnt_r[1][15:8];
                IDX_T1_CNTL: rdata_r[7:0] <= cnt_r[1][7:0];
                IDX_FLAGS: rdata_r[7:0] <= {6'h00, flag_r[1], flag_r[0]};
                default: rdata_r <= '0;
            endcase
        end
    end

    // Control and reload registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int k = 0; k < NUM_TIMERS; k++) begin
                ctrl_r[k] <= RST_BYTE;
                rlh_r[k] <= RST_BYTE;
                rll_r[k] <= RST_BYTE;
            end
        end else if (wr_commit & be_ok) begin
            unique case (avs_address)
                IDX_T0_CTRL: ctrl_r[0] <= wd & CTRL_WMASK;
                IDX_T1_CTRL: ctrl_r[1] <= wd & CTRL_WMASK;
                IDX_T0_RLH: rlh_r[0] <= wd;
                IDX_T0_RLL: rll_r[0] <= wd;
                IDX_T1_RLH: rlh_r[1] <= wd;
                IDX_T1_RLL: rll_r[1] <= wd;
                default: ;
            endcase
        end
    end

    // Timers 2 and 3 live elsewhere; only their flags are kept here
    // masked flag update
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            t23_r <= 2'h0;
        end else if (run_wr_hit) begin
            if (wd[T2_IDX]) begin
                t23_r[0] <= wd[RUN_FLAG_LO + T2_IDX];
            end
            if (wd[T3_IDX]) begin
                t23_r[1] <= wd[RUN_FLAG_LO + T3_IDX];
            end
        end
    end

    // Trimming oscillator arrives asynchronously
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lfo_s1_r <= 1'b0;
            lfo_s2_r <= 1'b0;
            lfo_s3_r <= 1'b0;
        end else begin
            lfo_s1_r <= lfo_in;
            lfo_s2_r <= lfo_s1_r;
            lfo_s3_r <= lfo_s2_r;
        end
    end
    assign lfo_rise = lfo_s2_r & ~lfo_s3_r;

    // Phase accumulators keep the average rate exact, jitter one cycle
    // carrier and slow ticks
    for (genvar d = 0; d < 2; d++) begin : g_rate
        localparam int RATE = (d == 0) ? CARRIER_HZ : SLOW_HZ;
        logic [ACC_W-1:0] acc_r;
        logic [ACC_W:0] sum;
        assign sum = {1'b0, acc_r} + (ACC_W+1)'(RATE);
        assign rate_tick[d] = sum >= (ACC_W+1)'(CLK_HZ);
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                acc_r <= '0;
            end else if (rate_tick[d]) begin
                acc_r <= ACC_W'(sum - (ACC_W+1)'(CLK_HZ));
            end else begin
                acc_r <= sum[ACC_W-1:0];
            end
        end
    end

    // Cascade ticks use registered underflows, so no loop forms
    // timer0 and timer1 cascade sources
    assign tick[0] = sel_tick(ctrl_r[0][CTRL_CLK_LO +: 2], rate_tick[0],
        rate_tick[1], timer2_underflow, uf_r[1]);
    assign tick[1] = sel_tick(ctrl_r[1][CTRL_CLK_LO +: 2], rate_tick[0],
        rate_tick[1], uf_r[0], timer2_underflow);

    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
        start_mode_t mode;
        logic trim;
        logic [CNT_W-1:0] reload;
        assign mode = start_mode_t'(ctrl_r[i][CTRL_MODE_LO +: 2]);
        assign trim = (mode == MODE_TRIM) | (mode == MODE_TRIM_UF);
        assign reload = {rlh_r[i], rll_r[i]};
        assign wr_run[i] = run_wr_hit & wd[i];
        assign hw_start[i] = ~run_r[i] & ((mode == MODE_TX_END & tx_end)
            | (trim & lfo_rise));
        assign hw_stop[i] = run_r[i] & ((trim & lfo_rise)
            | (~trim & ctrl_r[i][CTRL_STOP_RX] & rx_first_bits));
        assign uf_now[i] = run_r[i] & tick[i] & (cnt_r[i] == CNT_ZERO);

        // Software wins over hardware in the same cycle
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                run_r[i] <= 1'b0;
                cnt_r[i] <= CNT_ZERO;
                uf_r[i] <= 1'b0;
            end else begin
                uf_r[i] <= 1'b0;
                if (wr_run[i]) begin
                    run_r[i] <= wd[RUN_FLAG_LO + i];
                    if (wd[RUN_FLAG_LO + i]) begin
                        cnt_r[i] <= reload;
                    end
                end else if (hw_stop[i]) begin
                    run_r[i] <= 1'b0;
                end else if (hw_start[i]) begin
                    run_r[i] <= 1'b1;
                    cnt_r[i] <= reload;
                end else if (uf_now[i]) begin
                    uf_r[i] <= (mode != MODE_TRIM);
                    if (ctrl_r[i][CTRL_AUTO] & mode != MODE_TRIM) begin
                        cnt_r[i] <= reload;
                    end else begin
                        run_r[i] <= 1'b0;
                    end
                end else if (run_r[i] & tick[i]) begin
                    cnt_r[i] <= cnt_r[i] - CNT_ONE;
                end
            end
        end

        // Sticky flag, write one to clear; a set in that cycle wins
        // underflow flag
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                flag_r[i] <= 1'b0;
            end else if (uf_r[i]) begin
                flag_r[i] <= 1'b1;
            end else if (wr_commit & be_ok & (avs_address == IDX_FLAGS)
                    & wd[i]) begin
                flag_r[i] <= 1'b0;
            end
        end
    end

    assign timer0_active_flag = run_r[0];
    assign timer1_active_flag = run_r[1];
    assign timer0_underflow_irq_flag = flag_r[0];
    assign timer_one_underflow_irq_flag = flag_r[1];

    sequence s_pending;
        req & ~ack_r;
    endsequence
    sequence s_answer;
        ~avs_waitrequest & ack_r;
    endsequence

    property p_bus_answer;
        @(posedge mclk) disable iff (sys_rst)
        s_pending |-> avs_waitrequest ##1 s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not on second edge");

    property p_mask_keep;
        @(posedge mclk) disable iff (sys_rst)
        run_wr_hit & ~wd[0] & ~hw_stop[0] & ~hw_start[0] & ~uf_now[0]
        |=> run_r[0] == $past(run_r[0]);
    endproperty
    a_mask_keep: assert property (p_mask_keep)
        else $error("unmasked running bit changed");

    property p_sw_start;
        @(posedge mclk) disable iff (sys_rst)
        run_wr_hit & wd[0] & wd[RUN_FLAG_LO] |=> run_r[0]
            && cnt_r[0] == $past({rlh_r[0], rll_r[0]});
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("masked start did not load and run");

    property p_sw_stop;
        @(posedge mclk) disable iff (sys_rst)
        run_wr_hit & wd[0] & ~wd[RUN_FLAG_LO] |=> ~run_r[0];
    endproperty
    a_sw_stop: assert property (p_sw_stop)
        else $error("masked stop ignored");

    property p_stop_rx;
        @(posedge mclk) disable iff (sys_rst)
        run_r[0] & rx_first_bits & ctrl_r[0][CTRL_STOP_RX]
            & ~ctrl_r[0][CTRL_MODE_LO + 1] & ~wr_run[0] |=> ~run_r[0];
    endproperty
    a_stop_rx: assert property (p_stop_rx)
        else $error("timer0 kept running after receive");

    property p_trim_norx;
        @(posedge mclk) disable iff (sys_rst)
        run_r[0] & rx_first_bits & ctrl_r[0][CTRL_MODE_LO + 1] & ~lfo_rise
            & ~wr_run[0] & ~uf_now[0] |=> run_r[0];
    endproperty
    a_trim_norx: assert property (p_trim_norx)
        else $error("receive stopped a trimming timer");

    property p_tx_start;
        @(posedge mclk) disable iff (sys_rst)
        ~run_r[0] & tx_end & ctrl_r[0][CTRL_MODE_LO +: 2] == MODE_TX_END
            & ~wr_run[0] |=> run_r[0];
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("no start at transmission end");

    property p_reload;
        @(posedge mclk) disable iff (sys_rst)
        uf_now[0] & ctrl_r[0][CTRL_AUTO] & ~wr_run[0] & ~hw_stop[0]
            & ctrl_r[0][CTRL_MODE_LO +: 2] != MODE_TRIM
            |=> run_r[0] && cnt_r[0] == $past({rlh_r[0], rll_r[0]});
    endproperty
    a_reload: assert property (p_reload)
        else $error("no reload on underflow");

    property p_stop_zero;
        @(posedge mclk) disable iff (sys_rst)
        uf_now[0] & ~ctrl_r[0][CTRL_AUTO] & ~wr_run[0] |=> ~run_r[0];
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("timer did not stop at zero");

    property p_flag;
        @(posedge mclk) disable iff (sys_rst)
        uf_now[1] & ~wr_run[1] & ~hw_stop[1]
            & ctrl_r[1][CTRL_MODE_LO +: 2] != MODE_TRIM
            |-> ##2 timer_one_underflow_irq_flag;
    endproperty
    a_flag: assert property (p_flag)
        else $error("underflow flag not set");

    property p_dec;
        @(posedge mclk) disable iff (sys_rst)
        run_r[0] & tick[0] & cnt_r[0] != CNT_ZERO & ~wr_run[0] & ~hw_stop[0]
            |=> cnt_r[0] == $past(cnt_r[0]) - CNT_ONE;
    endproperty
    a_dec: assert property (p_dec)
        else $error("count did not step by one");

endmodule

// ### hw/timer_unit_pkg.sv
package timer_unit_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int NUM_TIMERS = 2;
    localparam int CNT_W = 16;
    localparam logic [ADDR_W-1:0] IDX_RUN = 5'h0e;
    localparam logic [ADDR_W-1:0] IDX_T0_CTRL = 5'h0f;
    localparam logic [ADDR_W-1:0] IDX_T0_RLH = 5'h10;
    localparam logic [ADDR_W-1:0] IDX_T0_RLL = 5'h11;
    localparam logic [ADDR_W-1:0] IDX_T0_CNTH = 5'h12;
    localparam logic [ADDR_W-1:0] IDX_T0_CNTL = 5'h13;
    localparam logic [ADDR_W-1:0] IDX_T1_CTRL = 5'h14;
    localparam logic [ADDR_W-1:0] IDX_T1_RLH = 5'h15;
    localparam logic [ADDR_W-1:0] IDX_T1_RLL = 5'h16;
    localparam logic [ADDR_W-1:0] IDX_T1_CNTH = 5'h17;
    localparam logic [ADDR_W-1:0] IDX_T1_CNTL = 5'h18;
    localparam logic [ADDR_W-1:0] IDX_FLAGS = 5'h1a;
    localparam int RUN_FLAG_LO = 4;
    localparam int T2_IDX = 2;
    localparam int T3_IDX = 3;
    localparam int CTRL_STOP_RX = 7;
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_AUTO = 3;
    localparam int CTRL_CLK_LO = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hbb;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam int CLK_HZ = 250_000_000;
    localparam int CARRIER_HZ = 13_560_000;
    localparam int SLOW_HZ = 211_875;
    localparam int ACC_W = 28;
    typedef enum logic [1:0] {
        MODE_MANUAL = 2'h0,
        MODE_TX_END = 2'h1,
        MODE_TRIM = 2'h2,
        MODE_TRIM_UF = 2'h3
    } start_mode_t;
    typedef enum logic [1:0] {
        CLK_CARRIER = 2'h0,
        CLK_SLOW = 2'h1,
        CLK_UF_A = 2'h2,
        CLK_UF_B = 2'h3
    } clk_sel_t;
endpackage
